// *** tat_activation.sv ***
// Terminal activation state machine with its timing supervision
// Overview of operation
// - INFO 2/4 in F3/F4: INFO 3 within 100 ms
// - INFO 2/4 in F4: stop INFO 1 within 5 ms
// - Unsyncable signal in F4: INFO 0 within 5 ms
// - F4 with INFO 0: INFO 1 until T3 expiry
// - F6/F7 INFO 0: INFO 0 in 250 us to 25 ms
// - Short INFO 0 gap then INFO 4: keep communication
// - INFO 0 over 1000 ms: communication is lost
// - Activation request in F3: F4, INFO 1, T3
// - Unsyncable signal for 5 ms in F4: go F5
// - Deactivation indication only after 500 ms-1 s timer
`default_nettype none

module tat_activation #(
    parameter int TICK_CYC = tat_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Received line signal, from the receiver on this clock
    input wire logic i_rx_info0,
    input wire logic i_rx_any,
    input wire logic i_rx_info2,
    input wire logic i_rx_info4,
    input wire logic i_frame_lost,
    // Power and upper layer
    input wire logic i_power,
    input wire logic i_act_req,
    // Transmit and status
    output logic [1:0] o_tx_info,
    output logic [7:0] o_state,
    output logic o_deact_ind,
    output logic o_comm_lost
);

    // -------------------------------------------------------------
    // Tick divider
    // -------------------------------------------------------------
    localparam logic [15:0] DIV_LAST = 16'(TICK_CYC - 1);

    logic [15:0] div_r;
    logic tick_r;

    // 250 us enable pulse, one every TICK_CYC device clocks
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div_r <= 16'h0000;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= (div_r == DIV_LAST);
            div_r <= (div_r == DIV_LAST) ? 16'h0000 : div_r + 16'h0001;
        end
    end

    // -------------------------------------------------------------
    // Interval timers
    // -------------------------------------------------------------
    tat_pkg::tat_state_t state_r, state_nxt;
    logic [1:0] tx_r, tx_nxt;
    logic link_r, lost_r, deact_r, loss_fire;
    logic t3_done, sig_done, dwait_done, loss_done;
    logic in_f4, in_f45, in_act, in_f7;

    assign in_f4 = (state_r == tat_pkg::ST_F4);
    assign in_f45 = in_f4 || (state_r == tat_pkg::ST_F5);
    assign in_f7 = (state_r == tat_pkg::ST_F7);
    assign in_act = in_f7 || (state_r == tat_pkg::ST_F6);

    // Attempt timer, restarted by the activation request
    tat_timer #(.LIMIT(tat_pkg::T3_TICKS)) u_t3 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clr(state_r == tat_pkg::ST_F3 && i_act_req),
        .i_run(in_f45),
        .i_tick(tick_r),
        .o_done(t3_done)
    );

    // Time since an unknown signal appeared in F4
    tat_timer #(.LIMIT(tat_pkg::SIG_TICKS)) u_sig (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clr(!(in_f4 && i_rx_any)),
        .i_run(1'b1),
        .i_tick(tick_r),
        .o_done(sig_done)
    );

    // Duration of received INFO 0 while synchronised or active
    tat_timer #(.LIMIT(tat_pkg::DEACT_TICKS)) u_dwait (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clr(!(in_act && i_rx_info0)),
        .i_run(1'b1),
        .i_tick(tick_r),
        .o_done(dwait_done)
    );

    // Time spent out of the active state after a call was up
    tat_timer #(.LIMIT(tat_pkg::LOSS_TICKS)) u_loss (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clr(in_f7 || !link_r),
        .i_run(1'b1),
        .i_tick(tick_r),
        .o_done(loss_done)
    );

    // -------------------------------------------------------------
    // State machine
    // -------------------------------------------------------------
    // Next state and transmitted signal
    always_comb
    begin
        state_nxt = state_r;
        tx_nxt = tx_r;
        unique case (state_r)
            tat_pkg::ST_F1:
                if (i_power)
                    state_nxt = tat_pkg::ST_F2;
            tat_pkg::ST_F2, tat_pkg::ST_F3, tat_pkg::ST_F5, tat_pkg::ST_F8:
            begin
                if (i_rx_info2)
                    state_nxt = tat_pkg::ST_F6;
                else if (i_rx_info4)
                    state_nxt = tat_pkg::ST_F7;
                else if (state_r == tat_pkg::ST_F3 && i_act_req)
                begin
                    state_nxt = tat_pkg::ST_F4;
                    tx_nxt = tat_pkg::TX_INFO1;
                end
                else if (state_r == tat_pkg::ST_F2 && i_rx_info0)
                    state_nxt = tat_pkg::ST_F3;
                else if (state_r == tat_pkg::ST_F8 && i_rx_info0)
                    state_nxt = tat_pkg::ST_F3;
                else if (state_r == tat_pkg::ST_F5 && t3_done)
                    state_nxt = tat_pkg::ST_F3;
            end
            tat_pkg::ST_F4:
            begin
                if (i_rx_info2)
                    state_nxt = tat_pkg::ST_F6;
                else if (i_rx_info4)
                    state_nxt = tat_pkg::ST_F7;
                else if (sig_done)
                begin
                    state_nxt = tat_pkg::ST_F5;
                    tx_nxt = tat_pkg::TX_INFO0;
                end
                else if (t3_done)
                begin
                    state_nxt = tat_pkg::ST_F3;
                    tx_nxt = tat_pkg::TX_INFO0;
                end
            end
            tat_pkg::ST_F6, tat_pkg::ST_F7:
            begin
                if (i_frame_lost)
                    state_nxt = tat_pkg::ST_F8;
                else if (dwait_done)
                    state_nxt = tat_pkg::ST_F3;
                else if (i_rx_info4)
                    state_nxt = tat_pkg::ST_F7;
                else if (i_rx_info2)
                    state_nxt = tat_pkg::ST_F6;
            end
            default:
                state_nxt = tat_pkg::ST_F1;
        endcase
        // Signal follows the state, but INFO 1 is kept when the next state is F4
        if (state_nxt == tat_pkg::ST_F6 || state_nxt == tat_pkg::ST_F7)
            tx_nxt = tat_pkg::TX_INFO3;
        else if (state_nxt != tat_pkg::ST_F4 || tx_nxt != tat_pkg::TX_INFO1)
            tx_nxt = tat_pkg::TX_INFO0;
        if (!i_power)
        begin
            state_nxt = tat_pkg::ST_F1;
            tx_nxt = tat_pkg::TX_INFO0;
        end
    end

    // State and transmit registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= tat_pkg::ST_F1;
            tx_r <= tat_pkg::TX_INFO0;
        end
        else
        begin
            state_r <= state_nxt;
            tx_r <= tx_nxt;
        end
    end

    // -------------------------------------------------------------
    // Communication supervision
    // -------------------------------------------------------------
    // Timer ran out with no re-entry to F7 now or on this edge
    assign loss_fire = link_r && loss_done && !in_f7
        && state_nxt != tat_pkg::ST_F7;
    // Call is up from F7 until the loss timer runs out
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            link_r <= 1'b0;
            lost_r <= 1'b0;
            deact_r <= 1'b0;
        end
        else
        begin
            deact_r <= loss_fire;
            if (state_nxt == tat_pkg::ST_F7)
            begin
                link_r <= 1'b1;
                lost_r <= 1'b0;
            end
            else if (loss_fire)
            begin
                link_r <= 1'b0;
                lost_r <= 1'b1;
            end
        end
    end

    assign o_tx_info = tx_r;
    assign o_state = state_r;
    assign o_deact_ind = deact_r;
    assign o_comm_lost = lost_r;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_info3_resp: assert property (
        (state_r == tat_pkg::ST_F3 && i_power && i_rx_info2)
        |=> (tx_r == tat_pkg::TX_INFO3 && state_r == tat_pkg::ST_F6))
        else $error("INFO 3 not sent after INFO 2 in F3");
    chk_info1_stop: assert property (
        (in_f4 && i_power && (i_rx_info2 || i_rx_info4))
        |=> tx_r != tat_pkg::TX_INFO1)
        else $error("INFO 1 still sent after INFO 2 or 4");
    // Cycles spent in F4 under an unknown signal, limit 5 ms
    localparam int ANY_MAX =
        tat_pkg::SIG_MS * 1000 / tat_pkg::TICK_US * TICK_CYC + 2;
    logic [31:0] any_cyc_r;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            any_cyc_r <= 32'h00000000;
        else
            any_cyc_r <= (in_f4 && i_power && i_rx_any) ?
                any_cyc_r + 32'h00000001 : 32'h00000000;
    end
    chk_unsync_info0: assert property (
        any_cyc_r <= 32'(ANY_MAX))
        else $error("Unknown signal did not give INFO 0 in time");
    chk_t3_expiry: assert property (
        (in_f4 && i_power && i_rx_info0 && t3_done)
        |=> (state_r == tat_pkg::ST_F3 && tx_r == tat_pkg::TX_INFO0))
        else $error("T3 expiry did not end INFO 1");
    chk_deact_min: assert property (
        (in_act && $rose(i_rx_info0) && i_power && !i_frame_lost)
        |=> tx_r == tat_pkg::TX_INFO3)
        else $error("Reaction to INFO 0 came too early");
    chk_deact_tx: assert property (
        (in_act && dwait_done && i_power && !i_frame_lost)
        |=> (state_r == tat_pkg::ST_F3 && tx_r == tat_pkg::TX_INFO0))
        else $error("INFO 0 not sent after received INFO 0");
    chk_resume_info3: assert property (
        (state_r == tat_pkg::ST_F8 && i_power && i_rx_info4
            && !i_rx_info2)
        |=> (in_f7 && tx_r == tat_pkg::TX_INFO3 && !o_comm_lost))
        else $error("INFO 4 did not resume communication");
    chk_loss_ind: assert property (
        (link_r && loss_done && !in_f7 && state_nxt != tat_pkg::ST_F7)
        |=> (o_deact_ind && o_comm_lost && !link_r))
        else $error("Loss of communication not flagged");
    chk_act_start: assert property (
        (state_r == tat_pkg::ST_F3 && i_power && i_act_req
            && !i_rx_info2 && !i_rx_info4)
        |=> (in_f4 && tx_r == tat_pkg::TX_INFO1))
        else $error("Activation request did not start INFO 1");
    chk_deact_pulse: assert property (
        o_deact_ind |=> !o_deact_ind)
        else $error("Deactivation indication longer than a cycle");
    chk_tick_gap: assert property (
        tick_r |=> !tick_r)
        else $error("Tick pulse repeated in consecutive cycles");

    cov_reach_f7: cover property (in_f7 && tx_r == tat_pkg::TX_INFO3);
    cov_reach_f5: cover property (state_r == tat_pkg::ST_F5);
    cov_loss: cover property (o_deact_ind);
    cov_resume: cover property (state_r == tat_pkg::ST_F8 ##1 in_f7);

endmodule

`default_nettype wire

// *** tat_activation_test.sv ***
// Self-checking bench for the activation timing supervisor
`default_nettype none

module tat_activation_test;
    timeunit 1ns;
    timeprecision 1ps;

    // Scaled tick: 250 us is TICK cycles, 1 ms is MS cycles
    localparam int TICK = 4;
    localparam int MS = 4 * TICK;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic power = 1'b1;
    logic act_req = 1'b0;
    logic [2:0] cmd = 3'h0;
    logic rx_info0, rx_any, rx_info2, rx_info4, frame_lost;
    logic [1:0] tx;
    logic [7:0] state;
    logic deact, lost;
    int fail_count = 0;
    int compares = 0;
    int deact_cnt = 0;
    int n;

    // -------------------------------------------------------------
    // Clock, far end and design
    // -------------------------------------------------------------
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    tat_nt_model nt (.i_clk(clk), .i_cmd(cmd), .o_rx_info0(rx_info0),
        .o_rx_any(rx_any), .o_rx_info2(rx_info2), .o_rx_info4(rx_info4),
        .o_frame_lost(frame_lost));

    tat_activation #(.TICK_CYC(TICK)) uut (.i_clk(clk), .i_rst_n(rst_n),
        .i_rx_info0(rx_info0), .i_rx_any(rx_any), .i_rx_info2(rx_info2),
        .i_rx_info4(rx_info4), .i_frame_lost(frame_lost), .i_power(power),
        .i_act_req(act_req), .o_tx_info(tx), .o_state(state),
        .o_deact_ind(deact), .o_comm_lost(lost));

    // Counts deactivation pulses
    always @(posedge clk)
    begin
        #1 if (deact === 1'b1) deact_cnt++;
    end

    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [2:0] c);
        @(negedge clk);
        cmd <= c;
    endtask

    task automatic request();
        @(negedge clk);
        act_req = 1'b1;
        @(negedge clk);
        act_req = 1'b0;
    endtask

    // Waits for a transmitted signal, bounded; n gives cycles taken
    task automatic wait_tx(input logic [1:0] exp, input int lim);
        n = 0;
        while (tx !== exp && n < lim)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (tx !== exp)
        begin
            check("tx wait", {6'h00, tx}, {6'h00, exp});
            stop_test();
        end
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic s_reset();
        repeat (8) @(posedge clk);
        #1 check("reset state", state, 8'h01);
        check("reset tx", {6'h00, tx}, 8'h00);
        check("reset lost", {7'h00, lost}, 8'h00);
        @(negedge clk);
        rst_n = 1'b1;
        send(3'h1);
        repeat (4) @(posedge clk);
        #1 check("idle state", state, 8'h04);
    endtask

    task automatic s_activate();
        request();
        check("act state", state, 8'h08);
        check("act tx", {6'h00, tx}, 8'h01);
        repeat (50 * MS) @(posedge clk);
        #1 check("info0 hold tx", {6'h00, tx}, 8'h01);
        send(3'h4);
        wait_tx(2'h3, 5 * MS);
        check("info4 state", state, 8'h40);
        check("info4 time", 8'(n <= 5 * MS), 8'h01);
    endtask

    task automatic s_short_gap();
        send(3'h1);
        wait_tx(2'h0, 25 * MS + 3);
        check("info0 min", 8'(n > TICK), 8'h01);
        repeat (100 * MS) @(posedge clk);
        send(3'h4);
        wait_tx(2'h3, 5 * MS);
        check("gap state", state, 8'h40);
        repeat (1100 * MS) @(posedge clk);
        #1 check("gap lost", {7'h00, lost}, 8'h00);
        check("gap deact", 8'(deact_cnt), 8'h00);
    endtask

    task automatic s_loss();
        send(3'h1);
        n = 0;
        while (deact !== 1'b1 && n < 1000 * MS + 4)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("loss late", 8'(n <= 1000 * MS + 3), 8'h01);
        check("loss early", 8'(n >= 500 * MS), 8'h01);
        check("loss flag", {7'h00, lost}, 8'h01);
        if (n >= 1000 * MS + 4)
            stop_test();
        send(3'h4);
        wait_tx(2'h3, 5 * MS);
        check("relink lost", {7'h00, lost}, 8'h00);
    endtask

    task automatic s_frame();
        send(3'h5);
        wait_tx(2'h0, 8);
        check("frame lost state", state, 8'h80);
        send(3'h4);
        wait_tx(2'h3, 5 * MS);
        check("frame resume state", state, 8'h40);
        check("frame resume lost", {7'h00, lost}, 8'h00);
    endtask

    task automatic s_unsync();
        send(3'h1);
        wait_tx(2'h0, 25 * MS + 3);
        request();
        send(3'h2);
        wait_tx(2'h0, 5 * MS + TICK + 3);
        check("any state", state, 8'h10);
        check("any early", 8'(n >= 5 * MS - TICK), 8'h01);
        check("any time", 8'(n <= 5 * MS + TICK + 3), 8'h01);
    endtask

    task automatic s_info2();
        send(3'h3);
        wait_tx(2'h3, 5 * MS);
        check("f5 info2 state", state, 8'h20);
        send(3'h1);
        wait_tx(2'h0, 25 * MS + 3);
        check("f6 info0 state", state, 8'h04);
        request();
        send(3'h3);
        wait_tx(2'h3, 5 * MS);
        check("f4 info2 state", state, 8'h20);
        check("f4 info2 time", 8'(n <= 5 * MS), 8'h01);
    endtask

    task automatic s_power();
        @(negedge clk);
        power = 1'b0;
        @(negedge clk);
        check("nopower state", state, 8'h01);
        check("nopower tx", {6'h00, tx}, 8'h00);
    endtask

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial
    begin
        s_reset();
        s_activate();
        s_short_gap();
        s_frame();
        s_loss();
        s_unsync();
        s_info2();
        s_power();
        stop_test();
    end
endmodule

`default_nettype wire

// *** tat_nt_model.sv ***
// Network termination model driving the terminal receiver indications
`default_nettype none

module tat_nt_model (
    // Clock
    input wire logic i_clk,
    // Line: 0 none, 1 INFO 0, 2 unsyncable, 3 INFO 2, 4 INFO 4, 5 no frame
    input wire logic [2:0] i_cmd,
    // Indications seen by the terminal receiver
    output logic o_rx_info0,
    output logic o_rx_any,
    output logic o_rx_info2,
    output logic o_rx_info4,
    output logic o_frame_lost
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] cmd_r = 3'h0;

    // Line changes one falling edge after the command, like a real far end
    always @(negedge i_clk)
    begin
        cmd_r <= i_cmd;
    end

    // One signal on the line at a time; code 5 drops framing
    assign o_rx_info0 = (cmd_r == 3'h1);
    assign o_rx_any = (cmd_r == 3'h2);
    assign o_rx_info2 = (cmd_r == 3'h3);
    assign o_rx_info4 = (cmd_r == 3'h4);
    assign o_frame_lost = (cmd_r == 3'h5);
endmodule

`default_nettype wire

// *** tat_pkg.sv ***
// Constants, codes and state type for the activation timing supervisor
`default_nettype none

package tat_pkg;

    // -------------------------------------------------------------
    // Clock and tick base
    // -------------------------------------------------------------
    localparam int CLK_NS = 25;
    localparam int TICK_NS = 250000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int TICK_US = TICK_NS / 1000;

    // -------------------------------------------------------------
    // Interval limits, in ticks
    // -------------------------------------------------------------
    localparam int TW = 17;
    // Longest time before the attempt is dropped
    localparam int T3_MS = 30000;
    localparam logic [TW-1:0] T3_TICKS = TW'((T3_MS * 1000) / TICK_US);
    // Longest wait for a known signal after any signal appears
    localparam int SIG_MS = 5;
    localparam logic [TW-1:0] SIG_TICKS = TW'((SIG_MS * 1000) / TICK_US);
    // Least reaction time to received INFO 0; one extra tick for phase
    localparam int INFO0_MIN_US = 250;
    localparam logic [TW-1:0] DEACT_TICKS =
        TW'((INFO0_MIN_US + TICK_US - 1) / TICK_US + 1);
    // Loss-of-communication timer, between 500 ms and 1000 ms
    localparam int LOSS_MS = 750;
    localparam logic [TW-1:0] LOSS_TICKS = TW'((LOSS_MS * 1000) / TICK_US);

    // -------------------------------------------------------------
    // Transmitted signal codes
    // -------------------------------------------------------------
    localparam logic [1:0] TX_INFO0 = 2'h0;
    localparam logic [1:0] TX_INFO1 = 2'h1;
    localparam logic [1:0] TX_INFO3 = 2'h3;

    // -------------------------------------------------------------
    // Activation states, one-hot
    // -------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_F1 = 8'h01,
        ST_F2 = 8'h02,
        ST_F3 = 8'h04,
        ST_F4 = 8'h08,
        ST_F5 = 8'h10,
        ST_F6 = 8'h20,
        ST_F7 = 8'h40,
        ST_F8 = 8'h80
    } tat_state_t;

endpackage

`default_nettype wire

// *** tat_timer.sv ***
// Saturating tick counter used for every interval of the supervisor
`default_nettype none

module tat_timer #(
    parameter logic [tat_pkg::TW-1:0] LIMIT = 17'h00001
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_clr,
    input wire logic i_run,
    input wire logic i_tick,
    // Status
    output logic o_done
);

    logic [tat_pkg::TW-1:0] cnt_r;

    // Count ticks while running, hold at the limit
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_r <= 17'h00000;
        else if (i_clr)
            cnt_r <= 17'h00000;
        else if (i_run && i_tick && cnt_r != LIMIT)
            cnt_r <= cnt_r + 17'h00001;
    end

    assign o_done = (cnt_r == LIMIT);

endmodule

`default_nettype wire
